// file: rtl/pmseq_pkg.sv
// package for the pressure sensor mode sequencer: offsets, fields, modes and timing
package pmseq_pkg;
    // register indices, each one word
    localparam logic [3:0] ADDR_STATUS  = 4'h0; // startup-done, clears on read
    localparam logic [3:0] ADDR_PWR     = 4'h1; // power_control_word
    localparam logic [3:0] ADDR_OSR     = 4'h2; // oversampling register
    localparam logic [3:0] ADDR_ODR     = 4'h3; // output rate prescaler select
    localparam logic [3:0] ADDR_CONFIG  = 4'h4; // iir coefficient
    localparam logic [3:0] ADDR_PRESS   = 4'h5; // pressure result
    localparam logic [3:0] ADDR_TEMP    = 4'h6; // temperature result
    localparam logic [3:0] ADDR_MSTAT   = 4'h7; // live mode and busy
    // field positions
    localparam int PWR_PRESS_EN_BIT = 0;
    localparam int PWR_TEMP_EN_BIT  = 1;
    localparam int PWR_MODE_LSB     = 4;
    localparam int OSR_P_LSB        = 0;
    localparam int OSR_T_LSB        = 3;
    localparam int STAT_POR_BIT     = 0;
    // reset values
    localparam logic [7:0] PWR_RST    = 8'h00;
    localparam logic [7:0] OSR_RST    = 8'h02;
    localparam logic [7:0] ODR_RST    = 8'h00;
    localparam logic [6:0] CONFIG_RST = 7'h00;
    localparam logic [2:0] OSR_MAX    = 3'h5;
    localparam logic [6:0] IIR_MAX    = 7'h7f;
    // timing
    localparam int CLK_HZ        = 125_000_000;
    localparam int BASE_RATE_HZ  = 200;
    localparam int BASE_TICK_CYC = CLK_HZ / BASE_RATE_HZ;
    localparam int CONV_SAMPLE_CYC = 16; // cycles per single conversion sample
    // mode field encodings
    localparam logic [1:0] MODE_SLEEP  = 2'h0;
    localparam logic [1:0] MODE_NORMAL = 2'h3;
    typedef enum logic [1:0] {
        PMSEQ_SLEEP  = 2'b00,
        PMSEQ_FORCED = 2'b01,
        PMSEQ_NORMAL = 2'b11
    } pmseq_mode_e;
    typedef enum logic [1:0] {
        PMSEQ_IDLE  = 2'b00,
        PMSEQ_TCONV = 2'b01,
        PMSEQ_PCONV = 2'b10,
        PMSEQ_DONE  = 2'b11
    } pmseq_meas_e;
    // register bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [31:0] wdata;
    } pmseq_bus_s;
    // result hand-off to the iir filter
    typedef struct packed {
        logic        valid;
        logic        iir_reset;
        logic [23:0] press;
        logic [23:0] temp;
    } pmseq_res_s;
endpackage : pmseq_pkg

// file: rtl/pmseq_top.sv
// pressure sensor power-mode and measurement sequencer with register port
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module pmseq_top import pmseq_pkg::*; #(
    parameter int BASE_TICK = BASE_TICK_CYC // cycles per 200 hz base tick
) (
    input  wire logic        clk,       // 125 mhz clock
    input  wire logic        nrst,      // async reset, active low
    input  wire logic        wr,        // register write strobe
    input  wire logic        rd,        // register read strobe
    input  wire logic [3:0]  addr,      // register index
    input  wire logic [31:0] wdata,     // write data
    input  wire logic [23:0] adc_press, // raw pressure sample
    input  wire logic [23:0] adc_temp,  // raw temperature sample
    output logic [31:0]      rdata,     // read data, cycle after rd
    output pmseq_res_s       res,       // result hand-off to iir
    output logic [6:0]       iir_coef   // filter coefficient, 0 bypasses
);
    // count width covers the base tick and the longest conversion (x32 samples);
    // a short simulation tick must not shrink the conversion counter
    localparam int TW = $clog2(((BASE_TICK > (1 << OSR_MAX) * CONV_SAMPLE_CYC) ?
                                BASE_TICK : (1 << OSR_MAX) * CONV_SAMPLE_CYC) + 1) + 1;

    // samples for an oversampling code, codes above 5 clamp to 32
    function automatic logic [6:0] osr_samples(input logic [2:0] code);
        logic [2:0] c;
        c = (code > OSR_MAX) ? OSR_MAX : code;
        osr_samples = 7'h01 << c;
    endfunction : osr_samples

    // result width: 16 bits plus one per doubling, 24 at x32 with coefficient 3 or more
    function automatic logic [4:0] res_bits(input logic [2:0] code, input logic [6:0] coef);
        logic [2:0] c;
        c = (code > OSR_MAX) ? OSR_MAX : code;
        if (c == OSR_MAX && coef >= 7'h03)
            res_bits = 5'h18;
        else
            res_bits = 5'h10 + {2'h0, c};
    endfunction : res_bits

    // keep the top bits of a raw sample, the rest zero
    function automatic logic [23:0] trim(input logic [23:0] raw, input logic [4:0] bits);
        logic [23:0] mask;
        mask = ~(24'hffffff >> bits);
        trim = raw & mask;
    endfunction : trim

    pmseq_bus_s bus; // grouped bus request
    assign bus = '{wr: wr, rd: rd, addr: addr, wdata: wdata};

    // register state
    logic        press_en, next_press_en;     // pressure enable
    logic        temp_en, next_temp_en;       // temperature enable
    logic [1:0]  mode_req, next_mode_req;     // last written mode field
    logic [2:0]  osr_p, next_osr_p;           // pressure oversampling
    logic [2:0]  osr_t, next_osr_t;           // temperature oversampling
    logic [4:0]  odr_sel, next_odr_sel;       // prescaler exponent
    logic [6:0]  coef, next_coef;             // iir coefficient
    logic        por_done, next_por_done;     // startup-done flag
    logic [31:0] next_rdata;                  // read mux
    // sequencer state
    pmseq_mode_e mode, next_mode;             // active mode
    pmseq_meas_e meas, next_meas;             // measurement step
    logic        pend, next_pend;             // deferred change held
    pmseq_mode_e pend_mode, next_pend_mode;   // the held mode
    logic [TW-1:0] conv_cnt, next_conv_cnt;   // conversion cycles left
    logic [TW-1:0] tick_cnt, next_tick_cnt;   // base tick divider
    logic [31:0]  per_cnt, next_per_cnt;      // base ticks left in period
    logic [23:0]  press_q, next_press_q;      // pressure result
    logic [23:0]  temp_q, next_temp_q;        // temperature result
    logic         res_v, next_res_v;          // one-cycle result strobe
    logic         iir_rst, next_iir_rst;      // filter reset request
    logic         tick;                        // 200 hz enable pulse
    logic         busy;                        // measurement running
    logic         mode_wr;                     // mode command this cycle
    pmseq_mode_e  cmd_mode;                    // decoded command

    assign busy    = (meas != PMSEQ_IDLE);
    assign mode_wr = bus.wr && bus.addr == ADDR_PWR;
    assign tick    = (tick_cnt == '0);

    // decode the commanded mode from write data
    always_comb begin
        case (bus.wdata[PWR_MODE_LSB +: 2])
            MODE_SLEEP:  cmd_mode = PMSEQ_SLEEP;
            MODE_NORMAL: cmd_mode = PMSEQ_NORMAL;
            default:     cmd_mode = PMSEQ_FORCED; // both 01 and 10
        endcase
    end

    // legal transitions: forced and normal only via sleep
    function automatic logic legal(input pmseq_mode_e from, input pmseq_mode_e to);
        legal = (from == PMSEQ_SLEEP) || (to == PMSEQ_SLEEP) || (from == to);
    endfunction : legal

    // register file next values; reads never stall the bus
    always_comb begin
        next_press_en = press_en;
        next_temp_en  = temp_en;
        next_mode_req = mode_req;
        next_osr_p    = osr_p;
        next_osr_t    = osr_t;
        next_odr_sel  = odr_sel;
        next_coef     = coef;
        next_por_done = por_done;
        next_rdata    = 32'h0;
        if (bus.wr) begin
            case (bus.addr)
                ADDR_PWR: begin
                    next_press_en = bus.wdata[PWR_PRESS_EN_BIT];
                    next_temp_en  = bus.wdata[PWR_TEMP_EN_BIT];
                    next_mode_req = bus.wdata[PWR_MODE_LSB +: 2];
                end
                ADDR_OSR: begin
                    next_osr_p = bus.wdata[OSR_P_LSB +: 3];
                    next_osr_t = bus.wdata[OSR_T_LSB +: 3];
                end
                ADDR_ODR:    next_odr_sel = bus.wdata[4:0];
                ADDR_CONFIG: next_coef = bus.wdata[6:0];
                default: ;                               // read-only or unmapped
            endcase
        end
        if (bus.rd) begin
            case (bus.addr)
                ADDR_STATUS: begin
                    next_rdata[STAT_POR_BIT] = por_done;
                    next_por_done = 1'b0; // read clears
                end
                ADDR_PWR: next_rdata[7:0] = {2'h0, mode_req, 2'h0, temp_en, press_en};
                ADDR_OSR: next_rdata[7:0] = {2'h0, osr_t, osr_p};
                ADDR_ODR: next_rdata[7:0] = {3'h0, odr_sel};
                ADDR_CONFIG: next_rdata[6:0] = coef;
                ADDR_PRESS:  next_rdata[23:0] = press_q;
                ADDR_TEMP:   next_rdata[23:0] = temp_q;
                ADDR_MSTAT:  next_rdata[3:0] = {pend, busy, mode};
                default: next_rdata = 32'h0; // unmapped reads zero
            endcase
        end
    end

    // register file flops; reset restores defaults and flags startup done
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            press_en <= PWR_RST[PWR_PRESS_EN_BIT];
            temp_en  <= PWR_RST[PWR_TEMP_EN_BIT];
            mode_req <= MODE_SLEEP;
            osr_p    <= OSR_RST[2:0];
            osr_t    <= OSR_RST[5:3];
            odr_sel  <= ODR_RST[4:0];
            coef     <= CONFIG_RST;
            por_done <= 1'b1;
            rdata    <= 32'h0;
        end else begin
            press_en <= next_press_en;
            temp_en  <= next_temp_en;
            mode_req <= next_mode_req;
            osr_p    <= next_osr_p;
            osr_t    <= next_osr_t;
            odr_sel  <= next_odr_sel;
            coef     <= next_coef;
            por_done <= next_por_done;
            rdata    <= next_rdata;
        end
    end

    // mode and measurement sequencer
    always_comb begin
        next_mode      = mode;
        next_meas      = meas;
        next_pend      = pend;
        next_pend_mode = pend_mode;
        next_conv_cnt  = conv_cnt;
        next_tick_cnt  = tick ? TW'(BASE_TICK - 1) : tick_cnt - 1'b1; // base divider
        next_per_cnt   = per_cnt;
        next_press_q   = press_q;
        next_temp_q    = temp_q;
        next_res_v     = 1'b0;
        next_iir_rst   = 1'b0;
        // enable falling from 1 to 0 resets the filter
        if ((press_en && !next_press_en) || (temp_en && !next_temp_en))
            next_iir_rst = 1'b1;
        // mode commands: deferred while busy, one pending at most
        if (mode_wr && legal(mode, cmd_mode)) begin
            if (busy) begin
                if (!pend) begin
                    next_pend      = 1'b1;
                    next_pend_mode = cmd_mode;
                end
            end else begin
                next_mode = cmd_mode;
                if (mode == PMSEQ_SLEEP && cmd_mode == PMSEQ_NORMAL)
                    next_iir_rst = 1'b1;
                if (cmd_mode != PMSEQ_SLEEP) begin
                    next_meas    = PMSEQ_TCONV; // start at once
                    next_conv_cnt = TW'(osr_samples(osr_t)) * TW'(CONV_SAMPLE_CYC);
                    next_per_cnt = 32'h1 << odr_sel;
                    next_tick_cnt = TW'(BASE_TICK - 1); // first period counts from this start
                end
            end
        end
        // standby countdown in normal mode, one step per base tick
        // a sleep command in this cycle wins, so no conversion starts in sleep
        if (mode == PMSEQ_NORMAL && next_mode == PMSEQ_NORMAL && !busy && tick) begin
            if (per_cnt <= 32'h1) begin
                next_meas     = PMSEQ_TCONV;
                next_conv_cnt = TW'(osr_samples(osr_t)) * TW'(CONV_SAMPLE_CYC);
                next_per_cnt  = 32'h1 << odr_sel; // prescaler ticks of 5 ms
            end else
                next_per_cnt = per_cnt - 32'h1;
        end else if (mode == PMSEQ_NORMAL && busy && tick && per_cnt > 32'h1)
            next_per_cnt = per_cnt - 32'h1;
        case (meas)
            PMSEQ_IDLE: ; // sleep does nothing here
            PMSEQ_TCONV: begin // temperature first
                if (!temp_en || conv_cnt <= TW'(1)) begin // skip when disabled
                    if (temp_en)
                        next_temp_q = trim(adc_temp, res_bits(osr_t, coef));
                    next_meas     = PMSEQ_PCONV;
                    next_conv_cnt = TW'(osr_samples(osr_p)) * TW'(CONV_SAMPLE_CYC);
                end else
                    next_conv_cnt = conv_cnt - 1'b1;
            end
            PMSEQ_PCONV: begin
                if (!press_en || conv_cnt <= TW'(1)) begin // skip when disabled
                    if (press_en)
                        next_press_q = trim(adc_press, res_bits(osr_p, coef));
                    next_meas = PMSEQ_DONE;
                end else
                    next_conv_cnt = conv_cnt - 1'b1;
            end
            PMSEQ_DONE: begin
                next_res_v = 1'b1; // hand results to filter
                next_meas  = PMSEQ_IDLE;
                if (mode == PMSEQ_FORCED)
                    next_mode = PMSEQ_SLEEP; // back to sleep alone
                // a command taken in this very cycle is applied here as well, never left stranded
                if (next_pend) begin
                    next_mode = next_pend_mode; // apply at measurement end
                    next_pend = 1'b0;
                    if (mode != PMSEQ_NORMAL && next_pend_mode == PMSEQ_NORMAL)
                        next_iir_rst = 1'b1;
                    if (next_pend_mode == PMSEQ_FORCED ||
                        (next_pend_mode == PMSEQ_NORMAL && mode != PMSEQ_NORMAL)) begin
                        next_meas     = PMSEQ_TCONV;
                        next_conv_cnt = TW'(osr_samples(osr_t)) * TW'(CONV_SAMPLE_CYC);
                        next_per_cnt  = 32'h1 << odr_sel;
                        next_tick_cnt = TW'(BASE_TICK - 1);
                    end
                end
            end
            default: next_meas = PMSEQ_IDLE;
        endcase
    end

    // sequencer flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode      <= PMSEQ_SLEEP;
            meas      <= PMSEQ_IDLE;
            pend      <= 1'b0;
            pend_mode <= PMSEQ_SLEEP;
            conv_cnt  <= '0;
            tick_cnt  <= '0;
            per_cnt   <= 32'h0;
            press_q   <= 24'h0;
            temp_q    <= 24'h0;
            res_v     <= 1'b0;
            iir_rst   <= 1'b0;
        end else begin
            mode      <= next_mode;
            meas      <= next_meas;
            pend      <= next_pend;
            pend_mode <= next_pend_mode;
            conv_cnt  <= next_conv_cnt;
            tick_cnt  <= next_tick_cnt;
            per_cnt   <= next_per_cnt;
            press_q   <= next_press_q;
            temp_q    <= next_temp_q;
            res_v     <= next_res_v;
            iir_rst   <= next_iir_rst;
        end
    end

    assign res      = '{valid: res_v, iir_reset: iir_rst, press: press_q, temp: temp_q};
    assign iir_coef = coef;

    // assertions
    property p_sleep_idle;
        @(posedge clk) disable iff (!nrst) (mode == PMSEQ_SLEEP && !busy) |=> !res_v;
    endproperty
    a_sleep_idle: assert property (p_sleep_idle) else $error("result in sleep");
    property p_forced_back;
        @(posedge clk) disable iff (!nrst) (meas == PMSEQ_DONE && mode == PMSEQ_FORCED && !pend && !mode_wr)
            |=> mode == PMSEQ_SLEEP;
    endproperty
    a_forced_back: assert property (p_forced_back) else $error("forced did not return");
    property p_defer;
        @(posedge clk) disable iff (!nrst) (busy && meas != PMSEQ_DONE) |=> mode == $past(mode);
    endproperty
    a_defer: assert property (p_defer) else $error("mode changed mid measurement");
    property p_one_pend;
        @(posedge clk) disable iff (!nrst) (pend && meas != PMSEQ_DONE) |=> pend_mode == $past(pend_mode);
    endproperty
    a_one_pend: assert property (p_one_pend) else $error("pending mode overwritten");
    property p_no_cross;
        @(posedge clk) disable iff (!nrst) (mode == PMSEQ_NORMAL) |=> mode != PMSEQ_FORCED;
    endproperty
    a_no_cross: assert property (p_no_cross) else $error("normal to forced");
    property p_por_clear;
        @(posedge clk) disable iff (!nrst) (rd && addr == ADDR_STATUS) |=> !por_done;
    endproperty
    a_por_clear: assert property (p_por_clear) else $error("startup flag kept");
    property p_order;
        @(posedge clk) disable iff (!nrst) (meas == PMSEQ_PCONV) |-> $past(meas) != PMSEQ_IDLE;
    endproperty
    a_order: assert property (p_order) else $error("pressure before temperature");
    property p_iir_norm;
        @(posedge clk) disable iff (!nrst) ($past(mode) == PMSEQ_SLEEP && mode == PMSEQ_NORMAL) |-> iir_rst;
    endproperty
    a_iir_norm: assert property (p_iir_norm) else $error("no filter reset");
    c_forced: cover property (@(posedge clk) disable iff (!nrst) mode == PMSEQ_FORCED ##[1:900] res_v);
    c_normal: cover property (@(posedge clk) disable iff (!nrst) mode == PMSEQ_NORMAL && res_v);
    c_pend:   cover property (@(posedge clk) disable iff (!nrst) pend && meas == PMSEQ_DONE);
endmodule : pmseq_top

// file: verif/pmseq_host.sv
// host-side register master model for the sequencer's register port
`timescale 1ns/1ps
module pmseq_host import pmseq_pkg::*; (
    input  wire logic        clk,   // bus clock
    output logic             wr,    // write strobe
    output logic             rd,    // read strobe
    output logic [3:0]       addr,  // register index
    output logic [31:0]      wdata  // write data
);
    // idle bus from time zero so nothing is unknown at reset release
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
    end
    // one-cycle write; the gap edge after it keeps a strobe from being set twice in one step
    task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : bus_write
    // one-cycle read; the bench monitor picks the data up in the cycle after
    task automatic bus_read(input logic [3:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
    endtask : bus_read
    // temperature oversampling picked from the pressure code: x2 at x16 and x32, else x1
    function automatic logic [2:0] rec_osr_t(input logic [2:0] osr_p);
        return (osr_p >= 3'h4) ? 3'h1 : 3'h0;
    endfunction : rec_osr_t
endmodule : pmseq_host

// file: verif/tb_top.sv
// self-checking bench for the pressure sensor mode sequencer
`timescale 1ns/1ps
module tb_top import pmseq_pkg::*; ;
    localparam int TICK = 50; // shortened base tick keeps the run short
    typedef struct packed {
        logic [47:0] exp;  // expected value
        logic [47:0] mask; // bits that matter
    } pmseq_note_s;
    logic        clk = 1'b0;   // 125 mhz clock
    logic        nrst = 1'b0;  // active-low reset
    logic        wr, rd;       // bus strobes
    logic [3:0]  addr;         // register index
    logic [31:0] wdata, rdata; // bus data
    logic [23:0] adc_press, adc_temp; // raw samples
    pmseq_res_s  res;          // result hand-off
    logic [6:0]  iir_coef;     // filter coefficient
    logic [31:0] seed = 32'd20368; // xorshift state
    logic        rd_seen = 1'b0;   // read taken last edge
    int err_total = 0, comparisons = 0, cyc = 0, vcount = 0, rcount = 0, vtime = 0;
    pmseq_note_s rdq[$], resq[$];  // pending read and result notes
    always #4 clk = ~clk;
    pmseq_top #(.BASE_TICK(TICK)) u_pmseq_top (.clk(clk), .nrst(nrst), .wr(wr), .rd(rd), .addr(addr),
        .wdata(wdata), .adc_press(adc_press), .adc_temp(adc_temp), .rdata(rdata), .res(res), .iir_coef(iir_coef));
    pmseq_host u_pmseq_host (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata));
    task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    // monitor: read data stands only in the cycle after the strobe, results on the valid pulse
    always @(posedge clk) begin
        pmseq_note_s n;
        cyc <= cyc + 1;
        rd_seen <= rd;
        if (rd_seen && rdq.size() != 0) begin
            n = rdq.pop_front();
            check("rdata", {16'h0, rdata} & n.mask, n.exp & n.mask);
        end
        if (res.valid === 1'b1) begin
            vcount <= vcount + 1;
            vtime <= cyc;
            if (resq.size() != 0) begin
                n = resq.pop_front();
                check("result", {res.press, res.temp} & n.mask, n.exp & n.mask);
            end
        end
        if (res.iir_reset === 1'b1) rcount <= rcount + 1;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // keep the top bits of a result word, low bits zero
    function automatic logic [23:0] msk(input int bits);
        return ~((24'h1 << (24 - bits)) - 24'h1);
    endfunction : msk
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        rdq.push_back({16'h0, e, 16'h0, m});
        u_pmseq_host.bus_read(a);
    endtask : rd_chk
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        u_pmseq_host.bus_write(a, d);
    endtask : wr_reg
    // bounded wait for the valid count to pass n0; a hang ends the run
    task automatic wait_valid(input int n0);
        for (int i = 0; i < 3000; i++) begin
            if (vcount > n0) return;
            @(posedge clk);
        end
        err_total++;
        $display("ERROR valid expected pulse seen none");
        print_verdict();
    endtask : wait_valid
    // one forced shot; each shot needs forced written again from sleep
    task automatic shot(input logic [7:0] pwr, input logic [47:0] e, input logic [47:0] m, output int lat);
        int n0;
        int t0;
        n0 = vcount;
        resq.push_back({e, m});
        wr_reg(ADDR_PWR, {24'h0, pwr});
        t0 = cyc;
        wait_valid(n0);
        lat = vtime - t0;
        idle(2);
    endtask : shot
    initial begin
        int lat0, lat, t, n, r0;
        logic [31:0] v;
        adc_press = 24'h0;
        adc_temp = 24'h0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        // defaults after reset; startup flag clears once read
        rd_chk(ADDR_STATUS, 32'h1, 32'h1);
        rd_chk(ADDR_STATUS, 32'h0, 32'h1);
        rd_chk(ADDR_MSTAT, 32'h0, 32'hf);
        rd_chk(ADDR_PWR, {24'h0, PWR_RST}, 32'hff);
        rd_chk(ADDR_OSR, {24'h0, OSR_RST}, 32'hff);
        rd_chk(4'h8, 32'h0, 32'hffffffff);
        check("iir_coef", 48'(iir_coef), 48'(CONFIG_RST));
        wr_reg(ADDR_CONFIG, {25'h0, IIR_MAX});
        idle(1);
        check("iir_coef", 48'(iir_coef), 48'(IIR_MAX));
        rd_chk(ADDR_CONFIG, {25'h0, IIR_MAX}, 32'h7f);
        wr_reg(ADDR_CONFIG, 32'h0);
        n = vcount;
        idle(300);
        check("valid_count", 48'(vcount), 48'(n));
        // oversampling codes 0 to 5 on each channel alone: length and result width
        for (int ch = 0; ch < 2; ch++) begin
            for (int c = 0; c < 6; c++) begin
                v = xs();
                adc_press <= v[23:0];
                adc_temp <= v[31:8];
                wr_reg(ADDR_OSR, (ch == 0) ? c : (c << 3));
                idle(1);
                shot((ch == 0) ? 8'h11 : 8'h12, {adc_press & msk(16 + c), adc_temp & msk(16 + c)},
                     (ch == 0) ? {24'hffffff, 24'h0} : {24'h0, 24'hffffff}, lat);
                if (c == 0) lat0 = lat;
                else check("latency", 48'(lat - lat0), 48'(CONV_SAMPLE_CYC * ((1 << c) - 1)));
            end
        end
        // both conversions, mode code 10 as forced
        wr_reg(ADDR_OSR, 32'h0);
        shot(8'h23, {adc_press & msk(16), adc_temp & msk(16)}, {48{1'b1}}, lat);
        // a skipped conversion still costs one cycle, so both enabled adds one conversion less that cycle
        check("latency", 48'(lat - lat0), 48'(CONV_SAMPLE_CYC - 1));
        rd_chk(ADDR_MSTAT, 32'h0, 32'hf);
        // x32 with coefficient 3 keeps the full word
        wr_reg(ADDR_OSR, 32'h5 | (32'(u_pmseq_host.rec_osr_t(3'h5)) << 3));
        wr_reg(ADDR_CONFIG, 32'h3);
        shot(8'h11, {adc_press, 24'h0}, {24'hffffff, 24'h0}, lat);
        // normal mode with prescaler 2: period, refresh, filter reset
        wr_reg(ADDR_CONFIG, 32'h0);
        wr_reg(ADDR_OSR, 32'h0); // measurement must fit inside one base tick
        wr_reg(ADDR_ODR, 32'h1);
        wr_reg(ADDR_PWR, 32'h03);
        idle(2);
        n = vcount;
        r0 = rcount;
        wr_reg(ADDR_PWR, 32'h33);
        wait_valid(n);
        t = vtime;
        wait_valid(n + 1);
        check("period", 48'(vtime - t), 48'(2 * TICK));
        v = xs();
        adc_press <= v[23:0];
        adc_temp <= v[31:8];
        idle(1);
        resq.push_back({adc_press & msk(16), adc_temp & msk(16), {48{1'b1}}});
        wait_valid(n + 2);
        check("period", 48'(vtime - t), 48'(4 * TICK));
        check("iir_reset", 48'(rcount - r0), 48'h1);
        wr_reg(ADDR_PWR, 32'h13);
        idle(2);
        rd_chk(ADDR_MSTAT, 32'h3, 32'h3);
        wr_reg(ADDR_PWR, 32'h03);
        rd_chk(ADDR_MSTAT, 32'h0, 32'h3);
        // change during a measurement waits; a second change meanwhile is dropped
        n = vcount;
        wr_reg(ADDR_PWR, 32'h33);
        wr_reg(ADDR_PWR, 32'h03);
        rd_chk(ADDR_MSTAT, 32'hf, 32'hf);
        wr_reg(ADDR_PWR, 32'h33); // legal on its own, so only the pending hold drops it
        wait_valid(n);
        idle(4);
        rd_chk(ADDR_MSTAT, 32'h0, 32'hf);
        n = vcount;
        idle(300);
        check("valid_count", 48'(vcount), 48'(n));
        print_verdict();
    end
endmodule : tb_top
